// ===== rtl/ext_bus_if.sv
// external memory bus interface: apb registers, bus cycle sequencer, pins
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: block stays in reset while rst_b is low.
// R2: boot pin low selects single-chip mode, high selects microprocessor mode.
// R3: data bus is 16 bits with width pin low, 8 bits when high.
// R4: outside keeps the width pin steady; low in single-chip mode.
// R5: low byte on lines 0-7; lines 8-15 carry data only in 16-bit mode.
// R6: a 20-bit address goes out on address lines 0 to 19.
// R7: multiplexed 8-bit bus shares address 0-7 with data 0-7.
// R8: multiplexed 16-bit bus shares address 1-8 with data 0-7.
// R9: four active-low space selects, each for one address space.
// R10: software picks split store strobes or one store strobe plus byte enable.
// R11: split scheme: even store strobe for even, odd strobe for odd writes.
// R12: combined scheme: store strobe on writes, byte enable low on odd access.
// R13: read strobe goes low on every external read in both schemes.
// R14: software must pick the combined scheme for an 8-bit bus.
// R15: address latch pulse lets outside logic capture the address.
// R16: hold request low puts the block in hold; grant is low there.
// R17: wait request low holds the strobe and stretches the access.
// R18: in hold, address, data and strobe pins are released.
module ext_bus_if #(
    parameter logic [3:0] STROBE_CYCLES = ebi_pkg::STROBE_CYCLES
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic [ebi_pkg::APB_AW-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       bootModePin,
    input  wire logic                       busWidthSelect,
    input  wire logic                       busReleaseRequest_b,
    input  wire logic                       waitRequest_b,
    input  wire logic [15:0]                dataIn,
    output logic      [15:0]                dataOut,
    output logic      [1:0]                 dataOe,
    output logic      [19:0]                addrOut,
    output logic                            addrOe,
    output logic      [3:0]                 spaceSelect_b,
    output logic                            ctlOe,
    output logic                            addressLatchPulse,
    output logic                            readStrobe_b,
    output logic                            storeStrobeEven_b,
    output logic                            storeStrobeOdd_b,
    output logic                            busReleaseGrant_b
);
    typedef struct packed {
        ebi_pkg::bus_state_t       st;
        logic                      combined;
        logic                      muxed;
        logic [ebi_pkg::ADDR_W-1:0] addr;
        logic [ebi_pkg::DATA_W-1:0] wdata;
        logic [ebi_pkg::DATA_W-1:0] rdata;
        logic                      isWrite;
        logic                      isWord;
        logic                      phase;
        logic [3:0]                cnt;
        logic                      procMode;
        logic                      modeTaken;
        logic [1:0]                startCnt;
        logic [ebi_pkg::ADDR_W-1:0] addrOut;
        logic [ebi_pkg::DATA_W-1:0] dataOut;
        logic [1:0]                dataOe;
        logic                      busOe;
        logic [3:0]                cs_b;
        logic                      ale;
        logic                      rd_b;
        logic                      wrEven_b;
        logic                      wrOdd_b;
        logic                      grant_b;
    } ebi_state_t;

    localparam ebi_state_t STATE_RST = '{
        st: ebi_pkg::ST_IDLE, cs_b: 4'hf, rd_b: 1'h1, wrEven_b: 1'h1,
        wrOdd_b: 1'h1, grant_b: 1'h1, default: '0};

    ebi_state_t s;
    ebi_state_t next_s;
    ext_pins_if pins ();

    pin_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .rawPins  ({bootModePin, busWidthSelect, busReleaseRequest_b,
                    waitRequest_b, dataIn}),
        .pins     (pins)
    );

    function automatic logic regMapped(input logic [ebi_pkg::APB_AW-1:0] a);
        regMapped = (a == ebi_pkg::CTRL_OFS) || (a == ebi_pkg::ADDR_OFS) ||
                    (a == ebi_pkg::WDATA_OFS) || (a == ebi_pkg::CMD_OFS) ||
                    (a == ebi_pkg::STAT_OFS) || (a == ebi_pkg::RDATA_OFS);
    endfunction

    // a 16-bit bus moves a word in one cycle, an 8-bit bus in two
    function automatic logic wordCycle(input ebi_state_t x, input logic bb);
        wordCycle = x.isWord && !bb;
    endfunction

    function automatic logic [ebi_pkg::ADDR_W-1:0] effAddr(
        input ebi_state_t x, input logic bb);
        if (wordCycle(x, bb)) begin
            effAddr = {x.addr[ebi_pkg::ADDR_W-1:1], 1'h0};
        end else begin
            effAddr = x.addr + ebi_pkg::ADDR_W'(x.phase);
        end
    endfunction

    function automatic logic [3:0] spaceDecode(
        input logic [ebi_pkg::ADDR_W-1:0] a);
        spaceDecode = ~(4'h1 << a[ebi_pkg::SPACE_HI:ebi_pkg::SPACE_LO]);
    endfunction

    logic busy;
    logic canStart;
    logic regHit;
    logic roReg;
    logic wrOk;
    logic apbAccess;
    logic apbWrite;
    logic curOdd;
    logic [ebi_pkg::ADDR_W-1:0] curEff;

    assign busy      = s.st != ebi_pkg::ST_IDLE;
    assign canStart  = !busy && s.procMode && s.modeTaken && pins.holdReq_b;
    assign regHit    = regMapped(paddr);
    assign roReg     = (paddr == ebi_pkg::STAT_OFS) ||
                       (paddr == ebi_pkg::RDATA_OFS);
    // settings stay frozen while a cycle runs on the pins
    assign wrOk      = regHit && !roReg && !busy &&
                       ((paddr != ebi_pkg::CMD_OFS) || canStart);
    assign apbAccess = psel && penable;
    assign apbWrite  = apbAccess && pwrite && wrOk;
    assign curEff    = effAddr(s, pins.byteBus);
    assign curOdd    = curEff[0] && !wordCycle(s, pins.byteBus);

    assign pready  = 1'h1;
    assign pslverr = apbAccess && (pwrite ? !wrOk : !regHit);

    always_comb begin
        prdata = 32'h0;
        case (paddr)
            ebi_pkg::CTRL_OFS: begin
                prdata[ebi_pkg::CTRL_COMB_BIT] = s.combined;
                prdata[ebi_pkg::CTRL_MUX_BIT]  = s.muxed;
            end
            ebi_pkg::ADDR_OFS:  prdata[ebi_pkg::ADDR_W-1:0] = s.addr;
            ebi_pkg::WDATA_OFS: prdata[ebi_pkg::DATA_W-1:0] = s.wdata;
            ebi_pkg::CMD_OFS: begin
                prdata[ebi_pkg::CMD_WR_BIT]   = s.isWrite;
                prdata[ebi_pkg::CMD_WORD_BIT] = s.isWord;
            end
            ebi_pkg::STAT_OFS: begin
                prdata[ebi_pkg::STAT_BUSY_BIT] = busy;
                prdata[ebi_pkg::STAT_HOLD_BIT] = s.st == ebi_pkg::ST_HOLD;
                prdata[ebi_pkg::STAT_BYTE_BIT] = pins.byteBus;
                prdata[ebi_pkg::STAT_PROC_BIT] = s.procMode;
                prdata[ebi_pkg::STAT_RDY_BIT]  = s.modeTaken;
            end
            ebi_pkg::RDATA_OFS: prdata[ebi_pkg::DATA_W-1:0] = s.rdata;
            default: prdata = 32'h0;
        endcase
    end

    always_comb begin
        logic [ebi_pkg::ADDR_W-1:0] eff;
        logic                      wc;
        logic                      odd;
        logic                      act;
        logic                      strobe;
        eff    = '0;
        wc     = 1'h0;
        odd    = 1'h0;
        act    = 1'h0;
        strobe = 1'h0;
        next_s = s;

        // boot level taken once the synchronisers hold real pin values
        if (!s.modeTaken) begin
            if (s.startCnt == ebi_pkg::SYNC_FILL) begin
                next_s.modeTaken = 1'h1;
                next_s.procMode  = pins.bootMode;  // [R2]
            end else begin
                next_s.startCnt = s.startCnt + 2'h1;
            end
        end

        unique case (s.st)
            ebi_pkg::ST_IDLE: begin
                // hold is granted only between accesses, never mid-cycle
                if (!pins.holdReq_b) begin
                    next_s.st = ebi_pkg::ST_HOLD;  // [R16]
                end
            end
            ebi_pkg::ST_LATCH: begin
                next_s.st  = ebi_pkg::ST_STROBE;
                next_s.cnt = STROBE_CYCLES - 4'h1;
            end
            ebi_pkg::ST_STROBE: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else if (pins.wait_b) begin  // [R17]
                    next_s.st = ebi_pkg::ST_RECOVER;
                    if (!s.isWrite) begin
                        if (wordCycle(s, pins.byteBus)) begin
                            next_s.rdata = pins.din;
                        end else if (pins.byteBus) begin
                            if (s.phase) begin
                                next_s.rdata[15:8] = pins.din[7:0];
                            end else begin
                                next_s.rdata = {8'h00, pins.din[7:0]};
                            end
                        end else begin
                            next_s.rdata = {8'h00, curOdd ? pins.din[15:8]
                                                          : pins.din[7:0]};
                        end
                    end
                end
            end
            ebi_pkg::ST_RECOVER: begin
                if (pins.byteBus && s.isWord && !s.phase) begin
                    next_s.phase = 1'h1;  // [R3]
                    next_s.st    = ebi_pkg::ST_LATCH;
                end else begin
                    next_s.st = ebi_pkg::ST_IDLE;
                end
            end
            ebi_pkg::ST_HOLD: begin
                if (pins.holdReq_b) begin
                    next_s.st = ebi_pkg::ST_IDLE;  // [R16]
                end
            end
            default: next_s.st = ebi_pkg::ST_IDLE;
        endcase

        if (apbWrite) begin
            case (paddr)
                ebi_pkg::CTRL_OFS: begin
                    // scheme choice for an 8-bit bus is left to software
                    next_s.combined = pwdata[ebi_pkg::CTRL_COMB_BIT];  // [R10]
                    next_s.muxed    = pwdata[ebi_pkg::CTRL_MUX_BIT];
                end
                ebi_pkg::ADDR_OFS:
                    next_s.addr = pwdata[ebi_pkg::ADDR_W-1:0];
                ebi_pkg::WDATA_OFS:
                    next_s.wdata = pwdata[ebi_pkg::DATA_W-1:0];
                ebi_pkg::CMD_OFS: begin
                    next_s.isWrite = pwdata[ebi_pkg::CMD_WR_BIT];
                    next_s.isWord  = pwdata[ebi_pkg::CMD_WORD_BIT];
                    next_s.phase   = 1'h0;
                    next_s.st      = ebi_pkg::ST_LATCH;
                end
                default: next_s.st = next_s.st;
            endcase
        end

        // pin values are derived from the next state so they leave flops
        eff    = effAddr(next_s, pins.byteBus);
        wc     = wordCycle(next_s, pins.byteBus);
        odd    = eff[0] && !wc;
        act    = (next_s.st == ebi_pkg::ST_LATCH) ||
                 (next_s.st == ebi_pkg::ST_STROBE);
        strobe = next_s.st == ebi_pkg::ST_STROBE;

        next_s.busOe   = next_s.procMode &&
                         (next_s.st != ebi_pkg::ST_HOLD);  // [R18]
        next_s.grant_b = next_s.st != ebi_pkg::ST_HOLD;  // [R16]
        if (act) begin
            next_s.addrOut = eff;  // [R6]
            next_s.cs_b    = spaceDecode(eff);  // [R9]
        end else begin
            next_s.cs_b = 4'hf;
        end
        next_s.ale  = next_s.st == ebi_pkg::ST_LATCH;  // [R15]
        next_s.rd_b = !(strobe && !next_s.isWrite);  // [R13]
        if (next_s.combined) begin
            next_s.wrEven_b = !(strobe && next_s.isWrite);  // [R12]
            next_s.wrOdd_b  = !(act && (odd || wc));  // [R12]
        end else begin
            next_s.wrEven_b = !(strobe && next_s.isWrite && !odd);  // [R11]
            next_s.wrOdd_b  = !(strobe && next_s.isWrite &&
                                (odd || wc));  // [R11]
        end

        next_s.dataOe = 2'h0;
        if (next_s.st == ebi_pkg::ST_LATCH && next_s.muxed) begin
            // address shares the low data lines during the latch pulse
            next_s.dataOut[7:0] = pins.byteBus ? eff[7:0]   // [R7]
                                               : eff[8:1];  // [R8]
            next_s.dataOe = 2'h1;
        end else if (strobe && next_s.isWrite) begin
            if (pins.byteBus) begin
                // upper lanes stay off on an 8-bit bus
                next_s.dataOut = {8'h00, next_s.phase ? next_s.wdata[15:8]
                                                      : next_s.wdata[7:0]};
                next_s.dataOe  = 2'h1;  // [R5]
            end else if (wc) begin
                next_s.dataOut = next_s.wdata;
                next_s.dataOe  = 2'h3;  // [R5]
            end else if (odd) begin
                next_s.dataOut = {next_s.wdata[7:0], 8'h00};
                next_s.dataOe  = 2'h2;
            end else begin
                next_s.dataOut = {8'h00, next_s.wdata[7:0]};
                next_s.dataOe  = 2'h1;  // [R5]
            end
        end
        if (!next_s.busOe) begin
            next_s.dataOe = 2'h0;  // [R18]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= STATE_RST;  // [R1]
        end else begin
            s <= next_s;
        end
    end

    assign dataOut           = s.dataOut;
    assign dataOe            = s.dataOe;
    assign addrOut           = s.addrOut;
    assign addrOe            = s.busOe;
    assign ctlOe             = s.busOe;
    assign spaceSelect_b     = s.cs_b;
    assign addressLatchPulse = s.ale;
    assign readStrobe_b      = s.rd_b;
    assign storeStrobeEven_b = s.wrEven_b;
    assign storeStrobeOdd_b  = s.wrOdd_b;
    assign busReleaseGrant_b = s.grant_b;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    boot_mode_a: assert property ($rose(s.modeTaken) |->  // [R2]
        s.procMode == $past(pins.bootMode))
        else $error("processor mode differs from boot pin");
    latch_pulse_a: assert property (addressLatchPulse |->  // [R15]
        !spaceSelect_b[0] || !spaceSelect_b[1] || !spaceSelect_b[2] ||
        !spaceSelect_b[3] ##1 !addressLatchPulse)
        else $error("latch pulse wider than one cycle");
    mux_byte_a: assert property (addressLatchPulse && s.muxed &&  // [R7]
        $past(pins.byteBus) |-> dataOut[7:0] == addrOut[7:0] && dataOe[0])
        else $error("8-bit shared lines miss address 0-7");
    mux_word_a: assert property (addressLatchPulse && s.muxed &&  // [R8]
        !$past(pins.byteBus) |-> dataOut[7:0] == addrOut[8:1])
        else $error("16-bit shared lines miss address 1-8");
    even_store_a: assert property (!s.combined &&  // [R11]
        !storeStrobeEven_b |-> !addrOut[0] && readStrobe_b)
        else $error("even store strobe on odd address");
    comb_store_a: assert property (s.combined && !readStrobe_b |->  // [R12]
        storeStrobeEven_b && (storeStrobeOdd_b == !addrOut[0] ||
        s.isWord))
        else $error("combined strobes wrong on read");
    read_width_a: assert property ($fell(readStrobe_b) |->  // [R13]
        !readStrobe_b [*3])
        else $error("read strobe shorter than minimum");
    one_space_a: assert property (!readStrobe_b |->  // [R9]
        $countones(~spaceSelect_b) == 1)
        else $error("not exactly one space select active");
    hold_release_a: assert property (s.st == ebi_pkg::ST_HOLD |->  // [R18]
        !busReleaseGrant_b && !addrOe && !ctlOe && dataOe == 2'h0)
        else $error("pins driven during hold");
    hold_enter_a: assert property (s.st == ebi_pkg::ST_IDLE &&  // [R16]
        !pins.holdReq_b |=> !busReleaseGrant_b)
        else $error("hold request not granted");
    wait_stretch_a: assert property (s.st == ebi_pkg::ST_STROBE &&  // [R17]
        s.cnt == 4'h0 && !pins.wait_b |=> s.st == ebi_pkg::ST_STROBE)
        else $error("access ended under wait request");
    upper_lane_a: assert property ($past(pins.byteBus) |->  // [R5]
        !dataOe[1])
        else $error("upper lanes driven on 8-bit bus");
endmodule
`default_nettype wire

// ===== rtl/ebi_pkg.sv
// shared constants and types of the external memory bus interface
package ebi_pkg;
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned APB_AW = 12;

    // register byte offsets
    localparam logic [APB_AW-1:0] CTRL_OFS  = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_OFS  = 12'h004;
    localparam logic [APB_AW-1:0] WDATA_OFS = 12'h008;
    localparam logic [APB_AW-1:0] CMD_OFS   = 12'h00c;
    localparam logic [APB_AW-1:0] STAT_OFS  = 12'h010;
    localparam logic [APB_AW-1:0] RDATA_OFS = 12'h014;

    // field positions
    localparam int unsigned CTRL_COMB_BIT = 0;
    localparam int unsigned CTRL_MUX_BIT  = 1;
    localparam int unsigned CMD_WR_BIT    = 0;
    localparam int unsigned CMD_WORD_BIT  = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_HOLD_BIT = 1;
    localparam int unsigned STAT_BYTE_BIT = 2;
    localparam int unsigned STAT_PROC_BIT = 3;
    localparam int unsigned STAT_RDY_BIT  = 4;

    // space select from the two top address bits
    localparam int unsigned SPACE_HI = 19;
    localparam int unsigned SPACE_LO = 18;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STROBE_MIN_NS = 300;
    localparam logic [3:0]  STROBE_CYCLES =
        4'((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0]  SYNC_FILL = 2'h2;

    // synchronised pin vector layout and its reset value
    localparam int unsigned PIN_W    = 20;
    localparam int unsigned BOOT_BIT = 19;
    localparam int unsigned BYTE_BIT = 18;
    localparam int unsigned HOLD_BIT = 17;
    localparam int unsigned WAIT_BIT = 16;
    localparam logic [PIN_W-1:0] PIN_RESET = 20'h30000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_LATCH   = 3'b001,
        ST_STROBE  = 3'b010,
        ST_RECOVER = 3'b011,
        ST_HOLD    = 3'b100
    } bus_state_t;
endpackage

// ===== rtl/ext_pins_if.sv
// synchronised external pin levels between the syncer and the sequencer
`timescale 1ns/10ps
`default_nettype none
interface ext_pins_if;
    logic        bootMode;
    logic        byteBus;
    logic        holdReq_b;
    logic        wait_b;
    logic [15:0] din;

    modport syncer (output bootMode, output byteBus, output holdReq_b,
                    output wait_b, output din);
    modport core   (input bootMode, input byteBus, input holdReq_b,
                    input wait_b, input din);
endinterface
`default_nettype wire

// ===== rtl/pin_sync.sv
// two-stage synchronisers for all external input pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic [ebi_pkg::PIN_W-1:0] rawPins,
    ext_pins_if.syncer                    pins
);
    typedef struct packed {
        logic [ebi_pkg::PIN_W-1:0] first;
        logic [ebi_pkg::PIN_W-1:0] second;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s.first  = rawPins;
        next_s.second = s.first;
    end

    // hold and wait reset to their idle high level
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= {ebi_pkg::PIN_RESET, ebi_pkg::PIN_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign pins.bootMode  = s.second[ebi_pkg::BOOT_BIT];
    assign pins.byteBus   = s.second[ebi_pkg::BYTE_BIT];
    assign pins.holdReq_b = s.second[ebi_pkg::HOLD_BIT];
    assign pins.wait_b    = s.second[ebi_pkg::WAIT_BIT];
    assign pins.din       = s.second[ebi_pkg::DATA_W-1:0];
endmodule
`default_nettype wire

// ===== verification/ext_mem_model.sv
// external memory model answering reads with an address pattern
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
    input  wire logic        core_clk,
    input  wire logic [19:0] addrOut,
    input  wire logic        readStrobe_b,
    input  wire logic        addressLatchPulse,
    input  wire logic        slow,
    output logic      [15:0] dataIn,
    output logic             waitRequest_b
);
    logic [15:0] last = 16'h0000;
    logic [3:0]  holdOff = 4'h0;
    // released lines show a changing inverse so stale data never matches
    assign dataIn = readStrobe_b ? ~last
                    : {addrOut[7:0] ^ 8'h5a, addrOut[7:0]};
    assign waitRequest_b = (holdOff == 4'h0);
    always @(posedge core_clk) begin
        last <= dataIn;
        if (slow && addressLatchPulse)
            holdOff <= 4'h6;
        else if (holdOff != 4'h0)
            holdOff <= holdOff - 4'h1;
    end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        core_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, errv, slow = 1'h0;
    logic        busWidthSelect = 1'h0;
    logic        bootModePin = 1'h1, busReleaseRequest_b = 1'h1;
    logic [15:0] dataIn, dataOut, aleData, sOut;
    logic [19:0] addrOut, aleAddr;
    logic [3:0]  spaceSelect_b, aleSel, nStb;
    logic [1:0]  dataOe, sOe;
    logic        addrOe, ctlOe, addressLatchPulse, readStrobe_b;
    logic        storeStrobeEven_b, storeStrobeOdd_b, busReleaseGrant_b;
    logic        waitRequest_b, sRd, sEven, sOdd;
    int          err_total = 0, n_checks = 0;

    ext_bus_if dut (.core_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .bootModePin,
        .busWidthSelect,
        .busReleaseRequest_b, .waitRequest_b, .dataIn, .dataOut, .dataOe,
        .addrOut, .addrOe, .spaceSelect_b, .ctlOe, .addressLatchPulse,
        .readStrobe_b, .storeStrobeEven_b, .storeStrobeOdd_b,
        .busReleaseGrant_b);
    ext_mem_model mem (.core_clk, .addrOut, .readStrobe_b,
        .addressLatchPulse, .slow, .dataIn, .waitRequest_b);

    initial forever #50 core_clk = ~core_clk;

    // pin snapshot: address phase at the latch pulse, last strobe cycle
    always @(posedge core_clk) begin
        if (addressLatchPulse) begin
            aleAddr <= addrOut;
            aleData <= dataOut;
            aleSel <= spaceSelect_b;
            nStb <= 4'h0;
        end else if (!readStrobe_b || !storeStrobeEven_b
                     || !storeStrobeOdd_b) begin
            nStb <= nStb + 4'h1;
            {sRd, sEven, sOdd} <= {readStrobe_b, storeStrobeEven_b,
                                   storeStrobeOdd_b};
            sOe <= dataOe;
            sOut <= dataOut;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        // no local limit: only the watchdog ends a hung access
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // issue a command, then poll up to 30 times until the sequencer is idle again
    task automatic run(input logic [31:0] c);
        int k;
        apb(1'h1, ebi_pkg::CMD_OFS, c);
        k = 0;
        do begin
            apb(1'h0, ebi_pkg::STAT_OFS, 32'h0);
            k++;
        end while (rdv[ebi_pkg::STAT_BUSY_BIT] !== 1'h0 && k < 30);
        if (rdv[ebi_pkg::STAT_BUSY_BIT] !== 1'h0)
            err_total++;
    endtask

    initial begin
        #(100 * 3000);
        err_total++;
        report_and_stop;
    end

    initial begin
        int k;
        repeat (5) @(posedge core_clk);
        chk({busReleaseGrant_b, readStrobe_b, addrOe}, 3'h6);
        rst_b <= 1'h1;
        repeat (6) @(posedge core_clk);
        apb(1'h0, ebi_pkg::STAT_OFS, 32'h0);
        chk(rdv, 32'h18);
        apb(1'h1, ebi_pkg::CTRL_OFS, 32'h0);
        apb(1'h1, ebi_pkg::ADDR_OFS, 32'h40010);
        apb(1'h1, ebi_pkg::WDATA_OFS, 32'hbeef);
        run(32'h3);
        chk(aleAddr, 20'h40010);
        chk(aleSel, 4'hd);
        chk({sEven, sOdd, sRd, sOe}, 5'h07);
        chk(sOut, 16'hbeef);
        run(32'h2);
        chk({sEven, sOdd, sRd}, 3'h6);
        apb(1'h0, ebi_pkg::RDATA_OFS, 32'h0);
        chk(rdv, 32'h4a10);
        apb(1'h1, ebi_pkg::ADDR_OFS, 32'h80013);
        apb(1'h1, ebi_pkg::WDATA_OFS, 32'ha5);
        run(32'h1);
        chk({sEven, sOdd, sOe}, 4'ha);
        chk(sOut[15:8], 8'ha5);
        chk(aleSel, 4'hb);
        apb(1'h1, ebi_pkg::CTRL_OFS, 32'h1);
        run(32'h0);
        chk({sEven, sOdd, sRd}, 3'h4);
        apb(1'h0, ebi_pkg::RDATA_OFS, 32'h0);
        chk(rdv, 32'h49);
        run(32'h1);
        chk({sEven, sOdd, sRd}, 3'h1);
        apb(1'h1, ebi_pkg::CTRL_OFS, 32'h3);
        apb(1'h1, ebi_pkg::ADDR_OFS, 32'h40010);
        slow <= 1'h1;
        run(32'h2);
        slow <= 1'h0;
        chk(aleData[7:0], 8'h08);
        chk(nStb > 4'h3, 1'h1);
        apb(1'h0, ebi_pkg::RDATA_OFS, 32'h0);
        chk(rdv, 32'h4a10);
        busReleaseRequest_b <= 1'h0;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (busReleaseGrant_b !== 1'h0 && k < 10);
        chk({busReleaseGrant_b, addrOe, ctlOe, dataOe}, 5'h00);
        apb(1'h1, ebi_pkg::CMD_OFS, 32'h0);
        chk(errv, 1'h1);
        busReleaseRequest_b <= 1'h1;
        repeat (6) @(posedge core_clk);
        chk({busReleaseGrant_b, addrOe, ctlOe}, 3'h7);
        apb(1'h0, 12'h020, 32'h0);
        chk(errv, 1'h1);
        // 8-bit multiplexed bus, combined scheme, word split in two bytes
        busWidthSelect <= 1'h1;
        apb(1'h1, ebi_pkg::CTRL_OFS, 32'h3);
        apb(1'h0, ebi_pkg::STAT_OFS, 32'h0);
        chk(rdv, 32'h1c);
        apb(1'h1, ebi_pkg::WDATA_OFS, 32'hbeef);
        run(32'h3);
        chk(aleData[7:0], 8'h11);
        chk({sEven, sOdd, sRd, sOe, sOut}, 21'h500be);
        run(32'h2);
        chk({sEven, sOdd, sRd}, 3'h4);
        apb(1'h0, ebi_pkg::RDATA_OFS, 32'h0);
        chk(rdv, 32'h1110);
        // second reset into single-chip mode, width pin tied low
        rst_b <= 1'h0;
        bootModePin <= 1'h0;
        busWidthSelect <= 1'h0;
        repeat (5) @(posedge core_clk);
        chk({addrOe, ctlOe, dataOe, busReleaseGrant_b}, 5'h1);
        rst_b <= 1'h1;
        repeat (6) @(posedge core_clk);
        apb(1'h0, ebi_pkg::STAT_OFS, 32'h0);
        chk(rdv, 32'h10);
        apb(1'h1, ebi_pkg::CMD_OFS, 32'h0);
        chk({errv, addrOe, ctlOe}, 3'h4);
        report_and_stop;
    end
endmodule
`default_nettype wire
